// File: logic/pspa_pkg.sv
`default_nettype none

package pspa_pkg;

  // ----------------------------------------------------------------
  // record placement in the cyclic input telegram
  // ----------------------------------------------------------------
  localparam logic [7:0] REC_FIRST_BYTE = 8'h0e;  // telegram byte 14
  localparam logic [7:0] REC_LAST_BYTE  = 8'h15;  // telegram byte 21
  localparam int         REC_BYTES      = 8;

  // module-relative byte indices
  localparam logic [2:0] BYTE_FIELD  = 3'h0;  // telegram 14
  localparam logic [2:0] BYTE_LOCK   = 3'h1;  // telegram 15
  localparam logic [2:0] BYTE_WSEG   = 3'h2;  // telegram 16
  localparam logic [2:0] BYTE_PSEG   = 3'h3;  // telegram 17
  localparam logic [2:0] BYTE_PAIR12 = 3'h4;  // telegram 18
  localparam logic [2:0] BYTE_PAIR3  = 3'h5;  // telegram 19
  localparam logic [2:0] BYTE_MATCH  = 3'h6;  // telegram 20

  // bit positions inside their byte
  localparam int BIT_WARN_FREE  = 0;
  localparam int BIT_PROT_FREE  = 1;
  localparam int BIT_FUNC_ACT   = 4;
  localparam int BIT_WARN_LOCK  = 0;
  localparam int BIT_PROT_LOCK  = 1;
  localparam int BIT_SEG1       = 0;
  localparam int BIT_SEG2       = 1;
  localparam int BIT_PAIR_LO    = 0;
  localparam int BIT_PAIR_HI    = 4;
  localparam int BIT_MATCH1     = 0;
  localparam int BIT_MATCH2     = 1;

  // field-pair numbering
  localparam logic [3:0] PAIR_MIN = 4'h1;
  localparam logic [3:0] PAIR_MAX = 4'ha;
  localparam logic [3:0] PAIR_NONE = 4'h0;

  // ----------------------------------------------------------------
  // software registers (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_REC_LO = 8'h04;
  localparam logic [7:0] REG_REC_HI = 8'h08;

  localparam int CTRL_PREDEF1_LSB = 0;
  localparam int CTRL_PREDEF2_LSB = 4;
  localparam int CTRL_CFG_BIT     = 8;
  localparam logic [3:0] PREDEF1_RESET = 4'h1;
  localparam logic [3:0] PREDEF2_RESET = 4'h2;
  localparam logic       CFG_RESET     = 1'b0;

  // ----------------------------------------------------------------
  // scanner status arriving from the evaluation core
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       warn_field_a_free;
    logic       prot_field_a_free;
    logic       func_a_running;
    logic       warn_a_restart_lock;
    logic       prot_a_restart_lock;
    logic       warn_a_seg1_free;
    logic       warn_a_seg2_free;
    logic       prot_a_seg1_free;
    logic       prot_a_seg2_free;
    logic [3:0] pair1;
    logic [3:0] pair2;
    logic [3:0] pair3;
  } pspa_scan_type;

  typedef struct packed {
    logic [3:0] predef1;
    logic [3:0] predef2;
    logic       func_a_cfg;
  } pspa_ctrl_type;

  typedef logic [REC_BYTES*8-1:0] pspa_record_type;

endpackage

`default_nettype wire

// File: logic/pspa_pair_check.sv
`default_nettype none

module pspa_pair_check (
  input  wire logic [3:0] i_pair1,
  input  wire logic [3:0] i_pair2,
  input  wire logic [3:0] i_pair3,
  input  wire logic [3:0] i_predef1,
  input  wire logic [3:0] i_predef2,
  output logic      [3:0] o_pair1,
  output logic      [3:0] o_pair2,
  output logic      [3:0] o_pair3,
  output logic            o_func_a_predef_match1,
  output logic            o_func_a_predef_match2
);

  // out-of-range numbers are shown as zero rather than passed on
  function automatic logic [3:0] clean_pair(input logic [3:0] p);
    clean_pair = (p >= pspa_pkg::PAIR_MIN && p <= pspa_pkg::PAIR_MAX) ? p : pspa_pkg::PAIR_NONE;
  endfunction

  always_comb begin
    o_pair1 = clean_pair(i_pair1);
    o_pair2 = clean_pair(i_pair2);
    o_pair3 = clean_pair(i_pair3);
    // active pair is the first selected one
    o_func_a_predef_match1 = (o_pair1 != pspa_pkg::PAIR_NONE) && (o_pair1 == i_predef1);
    o_func_a_predef_match2 = (o_pair1 != pspa_pkg::PAIR_NONE) && (o_pair1 == i_predef2);
  end

endmodule // pspa_pair_check

`default_nettype wire

// File: logic/pspa_packer.sv
// Overview of operation
// - byte 17 bit 0 shows protective segment 1, 0 occupied and 1 free.
// - byte 17 bit 1 shows protective segment 2, 0 occupied and 1 free, bits 2-7 reserved.
// - byte 14 bit 4 is 1 while function A is active and configured, else 0.
// - byte 15 bit 0 is 1 while the warning-field restart interlock is active.
// - byte 15 bit 1 is 1 while the protective-field restart interlock is active, bits 2-7 reserved.
// - three pair numbers 1 to 10 sit in byte 18 low, byte 18 high and byte 19 low nibbles.
// - byte 14 bit 0 shows the warning field and bit 1 the protective field, 0 occupied and 1 free.
// - byte 16 bits 0 and 1 show warning segments 1 and 2 occupancy.
// - byte 20 bits 0 and 1 are 1 when the active pair equals predefined pair 1 or 2.
`default_nettype none

module pspa_packer (
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_rst,
  input  wire pspa_pkg::pspa_scan_type i_scan,
  input  wire logic                    i_tel_rd,
  input  wire logic [7:0]              i_tel_addr,
  output logic      [7:0]              o_tel_data,
  output logic                         o_tel_hit,
  output pspa_pkg::pspa_record_type    o_record,
  input  wire logic [7:0]              i_reg_addr,
  input  wire logic [31:0]             i_reg_wdata,
  input  wire logic                    i_reg_wr,
  input  wire logic                    i_reg_rd,
  output logic      [31:0]             o_reg_rdata
);

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  pspa_pkg::pspa_ctrl_type ctrl_q, ctrl_d;

  always_comb begin
    ctrl_d = ctrl_q;
    if (i_reg_wr && i_reg_addr == pspa_pkg::REG_CTRL) begin
      ctrl_d.predef1    = i_reg_wdata[pspa_pkg::CTRL_PREDEF1_LSB +: 4];
      ctrl_d.predef2    = i_reg_wdata[pspa_pkg::CTRL_PREDEF2_LSB +: 4];
      ctrl_d.func_a_cfg = i_reg_wdata[pspa_pkg::CTRL_CFG_BIT];
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q.predef1    <= pspa_pkg::PREDEF1_RESET;
      ctrl_q.predef2    <= pspa_pkg::PREDEF2_RESET;
      ctrl_q.func_a_cfg <= pspa_pkg::CFG_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------------------------------
  // record assembly
  // ----------------------------------------------------------------
  logic [3:0] pair1_c, pair2_c, pair3_c;
  logic       match1_c, match2_c;

  pspa_pair_check u_pair_check (
    .i_pair1                (i_scan.pair1),
    .i_pair2                (i_scan.pair2),
    .i_pair3                (i_scan.pair3),
    .i_predef1              (ctrl_q.predef1),
    .i_predef2              (ctrl_q.predef2),
    .o_pair1                (pair1_c),
    .o_pair2                (pair2_c),
    .o_pair3                (pair3_c),
    .o_func_a_predef_match1 (match1_c),
    .o_func_a_predef_match2 (match2_c)
  );

  logic [7:0] rec_q [pspa_pkg::REC_BYTES];
  logic [7:0] rec_d [pspa_pkg::REC_BYTES];

  always_comb begin
    for (int i = 0; i < pspa_pkg::REC_BYTES; i++) begin
      rec_d[i] = 8'h00;
    end
    rec_d[pspa_pkg::BYTE_FIELD][pspa_pkg::BIT_WARN_FREE] = i_scan.warn_field_a_free;
    rec_d[pspa_pkg::BYTE_FIELD][pspa_pkg::BIT_PROT_FREE] = i_scan.prot_field_a_free;
    // a running function that software has not configured is not reported
    rec_d[pspa_pkg::BYTE_FIELD][pspa_pkg::BIT_FUNC_ACT] = i_scan.func_a_running & ctrl_q.func_a_cfg;
    rec_d[pspa_pkg::BYTE_LOCK][pspa_pkg::BIT_WARN_LOCK] = i_scan.warn_a_restart_lock;
    rec_d[pspa_pkg::BYTE_LOCK][pspa_pkg::BIT_PROT_LOCK] = i_scan.prot_a_restart_lock;
    rec_d[pspa_pkg::BYTE_WSEG][pspa_pkg::BIT_SEG1] = i_scan.warn_a_seg1_free;
    rec_d[pspa_pkg::BYTE_WSEG][pspa_pkg::BIT_SEG2] = i_scan.warn_a_seg2_free;
    rec_d[pspa_pkg::BYTE_PSEG][pspa_pkg::BIT_SEG1] = i_scan.prot_a_seg1_free;
    rec_d[pspa_pkg::BYTE_PSEG][pspa_pkg::BIT_SEG2] = i_scan.prot_a_seg2_free;
    rec_d[pspa_pkg::BYTE_PAIR12][pspa_pkg::BIT_PAIR_LO +: 4] = pair1_c;
    rec_d[pspa_pkg::BYTE_PAIR12][pspa_pkg::BIT_PAIR_HI +: 4] = pair2_c;
    rec_d[pspa_pkg::BYTE_PAIR3][pspa_pkg::BIT_PAIR_LO +: 4] = pair3_c;
    rec_d[pspa_pkg::BYTE_MATCH][pspa_pkg::BIT_MATCH1] = match1_c;
    rec_d[pspa_pkg::BYTE_MATCH][pspa_pkg::BIT_MATCH2] = match2_c;
  end

  // reset shows all fields occupied, the safe reading for a consumer
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < pspa_pkg::REC_BYTES; i++) begin
        rec_q[i] <= 8'h00;
      end
    end else begin
      rec_q <= rec_d;
    end
  end

  always_comb begin
    for (int i = 0; i < pspa_pkg::REC_BYTES; i++) begin
      o_record[i*8 +: 8] = rec_q[i];
    end
  end

  // ----------------------------------------------------------------
  // telegram byte fetch
  // ----------------------------------------------------------------
  function automatic logic in_record(input logic [7:0] a);
    in_record = (a >= pspa_pkg::REC_FIRST_BYTE) && (a <= pspa_pkg::REC_LAST_BYTE);
  endfunction

  logic [7:0] tel_data_q, tel_data_d;
  logic       tel_hit_q, tel_hit_d;
  logic [7:0] tel_off;

  always_comb begin
    tel_off    = i_tel_addr - pspa_pkg::REC_FIRST_BYTE;
    tel_hit_d  = i_tel_rd && in_record(i_tel_addr);
    tel_data_d = tel_hit_d ? rec_q[tel_off[2:0]] : 8'h00;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tel_data_q <= 8'h00;
      tel_hit_q  <= 1'b0;
    end else begin
      tel_data_q <= tel_data_d;
      tel_hit_q  <= tel_hit_d;
    end
  end

  assign o_tel_data = tel_data_q;
  assign o_tel_hit  = tel_hit_q;

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  logic [31:0] rdata_q, rdata_d;

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        pspa_pkg::REG_CTRL:   rdata_d = {23'h000000, ctrl_q.func_a_cfg, ctrl_q.predef2, ctrl_q.predef1};
        pspa_pkg::REG_REC_LO: rdata_d = o_record[31:0];
        pspa_pkg::REG_REC_HI: rdata_d = o_record[63:32];
        default:              rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  // the edge that ends reset still loads reset values, so skip the cycle after it
  chk_prot_seg1_bit: assert property (!$past(i_rst) |-> o_record[24] == $past(i_scan.prot_a_seg1_free))
    else $error("protective segment 1 bit wrong");
  chk_prot_seg2_bit: assert property (!$past(i_rst) |-> o_record[25] == $past(i_scan.prot_a_seg2_free))
    else $error("protective segment 2 bit wrong");
  chk_func_active: assert property (!$past(i_rst)
    |-> o_record[4] == ($past(i_scan.func_a_running) && $past(ctrl_q.func_a_cfg)))
    else $error("function active flag wrong");
  chk_warn_lock_bit: assert property (!$past(i_rst) |-> o_record[8] == $past(i_scan.warn_a_restart_lock))
    else $error("warning interlock bit wrong");
  chk_prot_lock_bit: assert property (!$past(i_rst) |-> o_record[9] == $past(i_scan.prot_a_restart_lock))
    else $error("protective interlock bit wrong");
  chk_pair_range: assert property (o_record[35:32] <= pspa_pkg::PAIR_MAX && o_record[39:36] <= pspa_pkg::PAIR_MAX)
    else $error("pair number out of range");
  chk_pair3_range: assert property (o_record[43:40] <= pspa_pkg::PAIR_MAX)
    else $error("pair 3 out of range");
  chk_pair1_pass: assert property (!$past(i_rst)
    && $past(i_scan.pair1) inside {[pspa_pkg::PAIR_MIN:pspa_pkg::PAIR_MAX]}
    |-> o_record[35:32] == $past(i_scan.pair1))
    else $error("pair 1 not placed");
  chk_field_free: assert property (!$past(i_rst)
    |-> o_record[1:0] == {$past(i_scan.prot_field_a_free), $past(i_scan.warn_field_a_free)})
    else $error("whole-field flags wrong");
  chk_warn_segs: assert property (!$past(i_rst)
    |-> o_record[17:16] == {$past(i_scan.warn_a_seg2_free), $past(i_scan.warn_a_seg1_free)})
    else $error("warning segment bits wrong");
  chk_match_one: assert property (o_record[48] |-> o_record[35:32] != 4'h0 && o_record[35:32] == $past(ctrl_q.predef1))
    else $error("predefined match 1 without equal pair");
  chk_match_two: assert property (o_record[49]
    |-> o_record[35:32] != 4'h0 && o_record[35:32] == $past(ctrl_q.predef2))
    else $error("predefined match 2 without equal pair");
  chk_match_found: assert property (!$past(i_rst) && $past(i_scan.pair1) == $past(ctrl_q.predef1)
    && $past(i_scan.pair1) inside {[pspa_pkg::PAIR_MIN:pspa_pkg::PAIR_MAX]} |-> o_record[48])
    else $error("predefined match 1 not reported");
  chk_reserved_zero: assert property (o_record[63:56] == 8'h00 && o_record[55:50] == 6'h00 && o_record[47:44] == 4'h0
    && o_record[31:26] == 6'h00 && o_record[23:18] == 6'h00 && o_record[15:10] == 6'h00 && o_record[7:5] == 3'h0
    && o_record[3:2] == 2'h0)
    else $error("reserved bit set");
  chk_tel_fetch: assert property (i_tel_rd && in_record(i_tel_addr) |=> o_tel_hit)
    else $error("telegram fetch missed");
  chk_tel_idle: assert property (!(i_tel_rd && in_record(i_tel_addr)) |=> !o_tel_hit && o_tel_data == 8'h00)
    else $error("telegram output outside a fetch");

  cov_prot_occupied: cover property (o_record[1] ##1 !o_record[1]);
  cov_match_one:     cover property (o_record[48]);
  cov_match_two:     cover property (o_record[49]);
  cov_tel_last_byte: cover property (i_tel_rd && i_tel_addr == pspa_pkg::REC_LAST_BYTE);

endmodule // pspa_packer

`default_nettype wire

// File: dv/pspa_bus_ctrl_model.sv
`default_nettype none

// ----------------------------------------------------------------
// cyclic input reader on the fieldbus controller side
// ----------------------------------------------------------------
module pspa_bus_ctrl_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_fetch,
  input  wire logic [7:0] i_byte_no,
  input  wire logic [7:0] i_tel_data,
  input  wire logic       i_tel_hit,
  output var  logic       o_tel_rd,
  output var  logic [7:0] o_tel_addr,
  output var  logic [7:0] o_byte,
  output var  logic       o_hit,
  output var  logic       o_done
);
  timeunit 1ns;
  timeprecision 1ps;

  logic pend_q;

  // idle address toggles so a stale byte number is never mistaken for a request
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tel_rd   <= 1'b0;
      o_tel_addr <= 8'h00;
      pend_q     <= 1'b0;
      o_byte     <= 8'h00;
      o_hit      <= 1'b0;
      o_done     <= 1'b0;
    end else begin
      o_tel_rd   <= i_fetch;
      o_tel_addr <= i_fetch ? i_byte_no : ~o_tel_addr;
      pend_q     <= o_tel_rd;
      o_done     <= pend_q;
      if (pend_q) begin
        o_byte <= i_tel_data;
        o_hit  <= i_tel_hit;
      end
    end
  end
endmodule // pspa_bus_ctrl_model

`default_nettype wire

// File: dv/pspa_packer_tb_top.sv
`default_nettype none

module pspa_packer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    pspa_pkg::pspa_scan_type scan;
    logic [63:0]             rec;
  } pspa_row_type;

  logic                    i_ref_clk   = 1'b0;
  logic                    i_rst       = 1'b1;
  pspa_pkg::pspa_scan_type i_scan      = '0;
  logic [7:0]              i_reg_addr  = 8'h00;
  logic [31:0]             i_reg_wdata = 32'h0;
  logic                    i_reg_wr    = 1'b0;
  logic                    i_reg_rd    = 1'b0;
  logic                    fetch       = 1'b0;
  logic [7:0]              byte_no     = 8'h00;
  logic                    tel_rd, tel_hit, got_hit, got_done;
  logic [7:0]              tel_addr, tel_data, got_byte;
  logic [63:0]             record;
  logic [31:0]             reg_rdata;
  int                      err_total   = 0;
  int                      checks_done = 0;

  // status bits in struct order, then pairs 1 to 3: valid, edge 10, out of range
  pspa_row_type rows [5] = '{
    '{{9'b000000000, 4'h0, 4'h0, 4'h0}, 64'h0000000000000000},
    '{{9'b101101010, 4'h1, 4'ha, 4'h3}, 64'h000103a101010111},
    '{{9'b010010101, 4'h2, 4'h5, 4'ha}, 64'h00020a5202020202},
    '{{9'b111111111, 4'hb, 4'hf, 4'h0}, 64'h0000000003030313},
    '{{9'b000000000, 4'ha, 4'h1, 4'hb}, 64'h0000001a00000000}};

  always #5 i_ref_clk = ~i_ref_clk;

  pspa_packer dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_scan(i_scan), .i_tel_rd(tel_rd),
    .i_tel_addr(tel_addr), .o_tel_data(tel_data), .o_tel_hit(tel_hit), .o_record(record),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(reg_rdata));

  pspa_bus_ctrl_model host (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_fetch(fetch), .i_byte_no(byte_no),
    .i_tel_data(tel_data), .i_tel_hit(tel_hit), .o_tel_rd(tel_rd), .o_tel_addr(tel_addr),
    .o_byte(got_byte), .o_hit(got_hit), .o_done(got_done));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_reg_wr    <= 1'b1;
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    @(posedge i_ref_clk);
    i_reg_wr    <= 1'b0;
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_ref_clk);
    i_reg_rd   <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_ref_clk);
    i_reg_rd   <= 1'b0;
    #1;
    check({32'h0, reg_rdata}, {32'h0, exp});
  endtask

  // controller result lands together with its done pulse
  task automatic fetch_chk(input logic [7:0] n, input logic [7:0] exp_b, input logic exp_h);
    @(posedge i_ref_clk);
    fetch   <= 1'b1;
    byte_no <= n;
    @(posedge i_ref_clk);
    fetch   <= 1'b0;
    for (int w = 0; w < 6 && got_done !== 1'b1; w++) begin
      @(posedge i_ref_clk);
      #1;
    end
    // a missing done pulse counts, so stale data cannot pass
    check({54'h0, got_done, got_hit, got_byte}, {54'h0, 1'b1, exp_h, exp_b});
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin : main
    repeat (4) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    #1;
    check(record, 64'h0);
    reg_chk(pspa_pkg::REG_CTRL, 32'h021);
    reg_wr(pspa_pkg::REG_CTRL, 32'h121);
    for (int i = 0; i < 5; i++) begin
      @(posedge i_ref_clk);
      i_scan <= rows[i].scan;
      @(posedge i_ref_clk);
      #1;
      check(record, rows[i].rec);
      for (int k = 0; k < 8; k++) begin
        fetch_chk(8'h0e + 8'(k), rows[i].rec[8*k +: 8], 1'b1);
      end
      reg_chk(pspa_pkg::REG_REC_LO, rows[i].rec[31:0]);
      reg_chk(pspa_pkg::REG_REC_HI, rows[i].rec[63:32]);
    end
    // function running but not configured
    @(posedge i_ref_clk);
    i_scan <= rows[1].scan;
    reg_wr(pspa_pkg::REG_CTRL, 32'h021);
    @(posedge i_ref_clk);
    #1;
    check(record, rows[1].rec & ~64'h10);
    // second predefined pair matches pair 10
    @(posedge i_ref_clk);
    i_scan <= rows[4].scan;
    reg_wr(pspa_pkg::REG_CTRL, 32'h1a5);
    @(posedge i_ref_clk);
    #1;
    check(record, 64'h0002001a00000000);
    reg_chk(pspa_pkg::REG_CTRL, 32'h1a5);
    // unmapped and read-only places
    reg_wr(8'h0c, 32'hffffffff);
    reg_chk(8'h0c, 32'h0);
    reg_wr(pspa_pkg::REG_REC_LO, 32'hffffffff);
    reg_chk(pspa_pkg::REG_REC_LO, 32'h00000000);
    reg_chk(pspa_pkg::REG_REC_HI, 32'h0002001a);
    fetch_chk(8'h0d, 8'h00, 1'b0);
    fetch_chk(8'h16, 8'h00, 1'b0);
    // reset in mid-run
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    @(posedge i_ref_clk);
    #1;
    check(record, 64'h0);
    @(posedge i_ref_clk);
    i_rst <= 1'b0;
    reg_chk(pspa_pkg::REG_CTRL, 32'h021);
    stop_test();
  end

  initial begin : watchdog
    repeat (20000) @(posedge i_ref_clk);
    err_total++;
    stop_test();
  end
endmodule // pspa_packer_tb_top

`default_nettype wire
